// ### reference_frequency_monitor.sv
// Reference frequency monitor with loss-of-reference status and register port.
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module reference_frequency_monitor #(
    parameter int GATE_DIV = 1
) (
    // Clock and reset.
    input  wire logic                      sys_clk,
    input  wire logic                      nrst,
    // Reference clocks, sampled on sys_clk.
    input  wire logic                      primary_ref_a,
    input  wire logic                      primary_ref_b,
    input  wire logic                      monitor_ref_in,
    // Switchover logic; zero selects primary_ref_a.
    input  wire logic                      active_ref_sel,
    input  wire logic                      requested_ref_sel,
    // Register port.
    input  wire logic [fm_pkg::ADDR_W-1:0] addr,
    input  wire logic [7:0]                wr_data,
    input  wire logic                      wr_en,
    input  wire logic                      rd_en,
    output logic      [7:0]                rd_data,
    // Status pin and interrupt.
    output logic                           ref_status_pin,
    output logic                           irq
);
    localparam int CW = fm_pkg::CNT_W;

    function automatic longint nominal_hz(input logic [7:0] c);
        return c[fm_pkg::CFG_NOMINAL] ? fm_pkg::NOMINAL_HZ_19 : fm_pkg::NOMINAL_HZ_25;
    endfunction : nominal_hz

    function automatic logic [CW-1:0] gate_edges(input logic [7:0] c);
        longint hz;
        hz = fm_pkg::MON_HZ_8K;
        if (!c[fm_pkg::CFG_MON_8K]) begin
            case (c[fm_pkg::CFG_MON_SEL +: 2])
                2'h0:    hz = fm_pkg::MON_HZ_10M;
                2'h1:    hz = fm_pkg::MON_HZ_19M;
                2'h2:    hz = fm_pkg::MON_HZ_25M;
                default: hz = fm_pkg::MON_HZ_38M;
            endcase
        end
        return CW'(hz * fm_pkg::GATE_MS / fm_pkg::MS_PER_S / GATE_DIV);
    endfunction : gate_edges

    function automatic logic [CW-1:0] tol_edges(input logic [7:0] c);
        longint ppm;
        case (c[fm_pkg::CFG_PPM +: 2])
            2'h0:    ppm = fm_pkg::PPM_10;
            2'h1:    ppm = fm_pkg::PPM_25;
            2'h2:    ppm = fm_pkg::PPM_50;
            default: ppm = fm_pkg::PPM_100;
        endcase
        return CW'(nominal_hz(c) * fm_pkg::GATE_MS * ppm / (fm_pkg::MS_PER_S * fm_pkg::PPM_SCALE * GATE_DIV));
    endfunction : tol_edges

    logic [7:0]                    cfg;
    logic [7:0]                    next_cfg;
    logic [2:0]                    ref_q;
    logic [2:0]                    ref_edge;
    logic                          sel_q;
    logic [2:0]                    loss;
    logic [2:0]                    loss_q;
    logic                          enable;
    logic                          act_edge;
    logic                          mon_edge;
    logic                          meas_fault;
    logic [CW-1:0]                 gate_cnt;
    logic [CW-1:0]                 exp_cnt;
    logic [CW-1:0]                 lo_cnt;
    logic [CW-1:0]                 hi_cnt;
    fm_pkg::meas_state_type        state;
    fm_pkg::meas_state_type        next_state;
    fm_pkg::freq_code_type         freq_code;
    fm_pkg::freq_code_type         next_code;
    fm_pkg::freq_code_type         code_q;
    logic [CW-1:0]                 act_cnt;
    logic [CW-1:0]                 next_act_cnt;
    logic [CW-1:0]                 mon_cnt;
    logic [CW-1:0]                 next_mon_cnt;
    logic [fm_pkg::IRQ_W-1:0]      irq_stat;
    logic [fm_pkg::IRQ_W-1:0]      next_irq_stat;
    logic [fm_pkg::IRQ_W-1:0]      irq_mask;
    logic [fm_pkg::IRQ_W-1:0]      next_irq_mask;
    logic [fm_pkg::IRQ_W-1:0]      events;
    logic [7:0]                    status_word;
    logic [7:0]                    next_rd_data;
    logic                          next_pin;
    logic                          next_irq;

    // Inputs are synchronous to sys_clk, so one sample is enough for edge detection.
    assign ref_edge = {monitor_ref_in, primary_ref_b, primary_ref_a} & ~ref_q;
    assign act_edge = active_ref_sel ? ref_edge[fm_pkg::REF_B] : ref_edge[fm_pkg::REF_A];
    assign mon_edge = ref_edge[fm_pkg::REF_MON];
    assign enable   = cfg[fm_pkg::CFG_ENABLE];
    assign gate_cnt = gate_edges(cfg);
    assign exp_cnt  = CW'(nominal_hz(cfg) * fm_pkg::GATE_MS / fm_pkg::MS_PER_S / GATE_DIV);
    assign lo_cnt   = exp_cnt - tol_edges(cfg);
    assign hi_cnt   = exp_cnt + tol_edges(cfg);
    assign meas_fault = loss[fm_pkg::REF_MON] | (active_ref_sel ? loss[fm_pkg::REF_B] : loss[fm_pkg::REF_A]);

    loss_probe_if probe [fm_pkg::NUM_REFS] ();

    generate
        for (genvar i = 0; i < fm_pkg::NUM_REFS; i++) begin : g_loss
            if (i == fm_pkg::REF_MON) begin : g_mon
                assign probe[i].tick  = cfg[fm_pkg::CFG_MON_8K] ? act_edge : 1'b1;
                assign probe[i].limit = !cfg[fm_pkg::CFG_MON_8K] ? fm_pkg::LOR_SYS_CYCLES :
                                        cfg[fm_pkg::CFG_NOMINAL] ? fm_pkg::LOR8K_EDGES_19 : fm_pkg::LOR8K_EDGES_25;
            end else begin : g_pri
                assign probe[i].tick  = 1'b1;
                assign probe[i].limit = fm_pkg::LOR_SYS_CYCLES;
            end
            assign probe[i].edge_seen = ref_edge[i];
            assign loss[i]            = probe[i].lost;
            loss_detector u_loss (
                .sys_clk (sys_clk),
                .nrst    (nrst),
                .probe   (probe[i])
            );
        end
    endgenerate

    always_comb begin
        next_state   = state;
        next_act_cnt = act_cnt;
        next_mon_cnt = mon_cnt;
        next_code    = freq_code;
        case (state)
            fm_pkg::ST_IDLE: begin
                next_state = fm_pkg::ST_ARM;
            end
            fm_pkg::ST_ARM: begin
                next_act_cnt = '0;
                next_mon_cnt = '0;
                if (mon_edge) begin
                    next_state = fm_pkg::ST_COUNT;
                end
            end
            fm_pkg::ST_COUNT: begin
                if (act_edge) begin
                    next_act_cnt = act_cnt + 1'b1;
                end
                if (mon_edge) begin
                    next_mon_cnt = mon_cnt + 1'b1;
                    if (mon_cnt + 1'b1 >= gate_cnt) begin
                        next_state = fm_pkg::ST_JUDGE;
                    end
                end
            end
            fm_pkg::ST_JUDGE: begin
                if (act_cnt < lo_cnt) begin
                    next_code = fm_pkg::FREQ_SLOW;
                end else if (act_cnt > hi_cnt) begin
                    next_code = fm_pkg::FREQ_FAST;
                end else begin
                    next_code = fm_pkg::FREQ_VALID;
                end
                next_state = fm_pkg::ST_ARM;
            end
            default: begin
                next_state = fm_pkg::ST_IDLE;
            end
        endcase
        // A switchover mid-gate would mix two references in one count.
        if (sel_q != active_ref_sel && state == fm_pkg::ST_COUNT) begin
            next_state = fm_pkg::ST_ARM;
        end
        if (meas_fault) begin
            next_code  = fm_pkg::FREQ_INDET;
            next_state = fm_pkg::ST_ARM;
        end
        if (!enable) begin
            next_state = fm_pkg::ST_IDLE;
            next_code  = fm_pkg::FREQ_VALID;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state     <= fm_pkg::ST_IDLE;
            act_cnt   <= '0;
            mon_cnt   <= '0;
            freq_code <= fm_pkg::FREQ_VALID;
        end else begin
            state     <= next_state;
            act_cnt   <= next_act_cnt;
            mon_cnt   <= next_mon_cnt;
            freq_code <= next_code;
        end
    end

    assign status_word = {2'h0, freq_code, sel_q, loss};
    assign events = {(freq_code != code_q) && (freq_code != fm_pkg::FREQ_VALID), loss & ~loss_q};

    always_comb begin
        next_cfg      = cfg;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_rd_data  = '0;
        if (wr_en && addr == fm_pkg::ADDR_CONFIG) begin
            next_cfg = wr_data;
        end
        if (wr_en && addr == fm_pkg::ADDR_IRQ_MASK) begin
            next_irq_mask = wr_data[fm_pkg::IRQ_W-1:0];
        end
        if (rd_en) begin
            case (addr)
                fm_pkg::ADDR_STATUS:     next_rd_data = status_word;
                fm_pkg::ADDR_CONFIG:     next_rd_data = cfg;
                fm_pkg::ADDR_IRQ_STATUS: next_rd_data = 8'(irq_stat);
                fm_pkg::ADDR_IRQ_MASK:   next_rd_data = 8'(irq_mask);
                default:                 next_rd_data = '0;
            endcase
        end
        // A read clears the flags, but an event in the same cycle survives.
        if (rd_en && addr == fm_pkg::ADDR_IRQ_STATUS) begin
            next_irq_stat = '0;
        end
        next_irq_stat = next_irq_stat | events;
        next_irq      = |(next_irq_stat & next_irq_mask);
        next_pin      = |freq_code;
        if (!enable) begin
            next_pin = requested_ref_sel ? loss[fm_pkg::REF_B] : loss[fm_pkg::REF_A];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cfg            <= fm_pkg::CONFIG_RESET;
            irq_mask       <= fm_pkg::IRQ_W'(fm_pkg::MASK_RESET);
            irq_stat       <= '0;
            rd_data        <= '0;
            ref_status_pin <= 1'b0;
            irq            <= 1'b0;
            ref_q          <= '0;
            sel_q          <= 1'b0;
            // Loss flags start set, so their history starts set too and reset raises no loss event.
            loss_q         <= '1;
            code_q         <= fm_pkg::FREQ_VALID;
        end else begin
            cfg            <= next_cfg;
            irq_mask       <= next_irq_mask;
            irq_stat       <= next_irq_stat;
            rd_data        <= next_rd_data;
            ref_status_pin <= next_pin;
            irq            <= next_irq;
            ref_q          <= {monitor_ref_in, primary_ref_b, primary_ref_a};
            sel_q          <= active_ref_sel;
            loss_q         <= loss;
            code_q         <= freq_code;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_idle_when_off: assert property (!enable |=> state == fm_pkg::ST_IDLE)
        else $error("monitor not idle while disabled");
    a_valid_window: assert property (state == fm_pkg::ST_JUDGE && enable && !meas_fault && act_cnt >= lo_cnt
                                     && act_cnt <= hi_cnt |=> freq_code == fm_pkg::FREQ_VALID)
        else $error("in-window count not reported valid");
    a_slow_report: assert property (state == fm_pkg::ST_JUDGE && enable && !meas_fault && act_cnt < lo_cnt
                                    |=> freq_code == fm_pkg::FREQ_SLOW)
        else $error("low count not reported slow");
    a_gate_length: assert property (state == fm_pkg::ST_COUNT && enable && !meas_fault && sel_q == active_ref_sel
                                    && mon_edge && mon_cnt + 1'b1 == gate_cnt |=> state == fm_pkg::ST_JUDGE)
        else $error("gate did not close at decoded length");
    a_switch_restart: assert property (state == fm_pkg::ST_COUNT && sel_q != active_ref_sel
                                       |=> state != fm_pkg::ST_JUDGE)
        else $error("count kept across reference change");
    a_indet_fault: assert property (enable && meas_fault |=> freq_code == fm_pkg::FREQ_INDET)
        else $error("fault not reported indeterminate");
    a_pin_or_status: assert property (enable |=> ref_status_pin == |$past(freq_code))
        else $error("status pin differs from status bits");
    a_pin_disabled: assert property (!enable && !requested_ref_sel |=> ref_status_pin == $past(loss[0]))
        else $error("status pin not showing requested loss");
    a_loss_readback: assert property (rd_en && addr == fm_pkg::ADDR_STATUS |=> rd_data[2:0] == $past(loss))
        else $error("loss bits not read back");

    c_valid: cover property (state == fm_pkg::ST_JUDGE ##1 freq_code == fm_pkg::FREQ_VALID);
    c_fast: cover property (state == fm_pkg::ST_JUDGE ##1 freq_code == fm_pkg::FREQ_FAST);
    c_slow: cover property (state == fm_pkg::ST_JUDGE ##1 freq_code == fm_pkg::FREQ_SLOW);
    c_irq: cover property ($rose(irq));
endmodule : reference_frequency_monitor

// ### fm_pkg.sv
// Shared constants and types for the reference frequency monitor.
package fm_pkg;
    // Register map; addresses are used as printed, one register per address.
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_STATUS     = 12'h021;
    localparam logic [11:0] ADDR_CONFIG     = 12'h083;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h090;
    localparam logic [11:0] ADDR_IRQ_MASK   = 12'h091;
    localparam logic [7:0]  CONFIG_RESET    = 8'h00;
    localparam logic [7:0]  MASK_RESET      = 8'h00;
    // Configuration fields.
    localparam int CFG_ENABLE  = 7;
    localparam int CFG_NOMINAL = 5;
    localparam int CFG_MON_8K  = 4;
    localparam int CFG_MON_SEL = 2;
    localparam int CFG_PPM     = 0;
    // Status fields and reference indices.
    localparam int ST_ACTIVE = 3;
    localparam int ST_FREQ   = 4;
    localparam int REF_A     = 0;
    localparam int REF_B     = 1;
    localparam int REF_MON   = 2;
    localparam int NUM_REFS  = 3;
    localparam int IRQ_FREQ  = 3;
    localparam int IRQ_W     = 4;
    // Rates and timing.
    localparam longint SYS_CLK_HZ    = 125_000_000;
    localparam longint LOR_MIN_HZ    = 1_000_000;
    localparam longint NOMINAL_HZ_25 = 25_000_000;
    localparam longint NOMINAL_HZ_19 = 19_440_000;
    localparam longint MON8K_MIN_HZ_25 = 6_100;
    localparam longint MON8K_MIN_HZ_19 = 4_700;
    localparam longint MON_HZ_8K  = 8_000;
    localparam longint MON_HZ_10M = 10_000_000;
    localparam longint MON_HZ_19M = 19_440_000;
    localparam longint MON_HZ_25M = 25_000_000;
    localparam longint MON_HZ_38M = 38_880_000;
    localparam longint PPM_10  = 10;
    localparam longint PPM_25  = 25;
    localparam longint PPM_50  = 50;
    localparam longint PPM_100 = 100;
    localparam longint PPM_SCALE = 1_000_000;
    localparam longint MS_PER_S  = 1_000;
    localparam longint GATE_MS   = 100;
    localparam int LIMIT_W = 13;
    localparam int CNT_W   = 23;
    localparam logic [LIMIT_W-1:0] LOR_SYS_CYCLES = LIMIT_W'(SYS_CLK_HZ / LOR_MIN_HZ);
    localparam logic [LIMIT_W-1:0] LOR8K_EDGES_25 = LIMIT_W'(NOMINAL_HZ_25 / MON8K_MIN_HZ_25);
    localparam logic [LIMIT_W-1:0] LOR8K_EDGES_19 = LIMIT_W'(NOMINAL_HZ_19 / MON8K_MIN_HZ_19);
    typedef enum logic [1:0] {
        FREQ_VALID = 2'h0,
        FREQ_SLOW  = 2'h1,
        FREQ_FAST  = 2'h2,
        FREQ_INDET = 2'h3
    } freq_code_type;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_ARM   = 2'h1,
        ST_COUNT = 2'h3,
        ST_JUDGE = 2'h2
    } meas_state_type;
endpackage : fm_pkg

// ### loss_probe_if.sv
// Link between the monitor and one loss-of-reference detector.
`timescale 1ns/10ps
interface loss_probe_if;
    logic                      tick;
    logic                      edge_seen;
    logic [fm_pkg::LIMIT_W-1:0] limit;
    logic                      lost;
    modport detector (input tick, input edge_seen, input limit, output lost);
    modport owner (output tick, output edge_seen, output limit, input lost);
endinterface : loss_probe_if

// ### loss_detector.sv
// Loss-of-reference detector: flags a clock whose edges stop for a set number of ticks.
`timescale 1ns/10ps
module loss_detector (
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // Probe link.
    loss_probe_if.detector  probe
);
    logic [fm_pkg::LIMIT_W-1:0] count;
    logic [fm_pkg::LIMIT_W-1:0] next_count;
    logic                       lost;
    logic                       next_lost;

    always_comb begin
        next_count = count;
        next_lost  = lost;
        if (probe.edge_seen) begin
            next_count = '0;
            next_lost  = 1'b0;
        end else if (probe.tick) begin
            if (count + 1'b1 >= probe.limit) begin
                next_lost = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    // Starts lost so that a missing clock is never reported present.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
            lost  <= 1'b1;
        end else begin
            count <= next_count;
            lost  <= next_lost;
        end
    end

    assign probe.lost = lost;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_loss_raise: assert property (probe.tick && !probe.edge_seen && count + 1'b1 >= probe.limit |=> lost)
        else $error("loss not raised after edge gap");
    a_loss_clear: assert property (probe.edge_seen |=> !lost)
        else $error("loss not cleared on clock edge");
endmodule : loss_detector

// ### ref_clock_source.sv
// Behavioural clock sources standing in for the three reference oscillators.
`timescale 1ns/10ps
module ref_clock_source (
    // Run controls, bit 0 for reference A, bit 1 for B, bit 2 for the monitor input.
    input  wire logic [2:0]  run,
    // Half periods in units of 10 ps.
    input  wire logic [15:0] half_a,
    input  wire logic [15:0] half_b,
    input  wire logic [15:0] half_m,
    // Clock outputs.
    output logic             clk_a,
    output logic             clk_b,
    output logic             clk_m
);
    // supported nominal rates
    // A stopped source stands low. The start offsets keep every edge off a sys_clk edge.
    // Primary edges also stay over 4 ns clear of monitor edges, away from a gate boundary.
    initial begin
        clk_a = 1'b0;
        #2;
        forever begin
            #(half_a * 0.01);
            clk_a = run[0] ? ~clk_a : 1'b0;
        end
    end
    initial begin
        clk_b = 1'b0;
        #7.5;
        forever begin
            #(half_b * 0.01);
            clk_b = run[1] ? ~clk_b : 1'b0;
        end
    end
    initial begin
        clk_m = 1'b0;
        #2.5;
        forever begin
            #(half_m * 0.01);
            clk_m = run[2] ? ~clk_m : 1'b0;
        end
    end
endmodule : ref_clock_source

// ### reference_frequency_monitor_test.sv
// Self-checking testbench for the reference frequency monitor.
`timescale 1ns/10ps
module reference_frequency_monitor_test;
    // The gate is shortened to 1000 monitor edges, so tolerance rounds to zero counts.
    localparam int GATE_DIV = 1000;
    logic                      sys_clk;
    logic                      nrst;
    logic                      clk_a;
    logic                      clk_b;
    logic                      clk_m;
    logic                      active_ref_sel;
    logic                      requested_ref_sel;
    logic [fm_pkg::ADDR_W-1:0] addr;
    logic [7:0]                wr_data;
    logic                      wr_en;
    logic                      rd_en;
    logic [7:0]                rd_data;
    logic                      ref_status_pin;
    logic                      irq;
    logic [2:0]                run;
    logic [7:0]                s;
    int                        n_fail;
    int                        check_count;

    ref_clock_source src (
        .run    (run),
        .half_a (16'h07d0),
        .half_b (16'h09c4),
        .half_m (16'h1388),
        .clk_a  (clk_a),
        .clk_b  (clk_b),
        .clk_m  (clk_m)
    );

    reference_frequency_monitor #(.GATE_DIV(GATE_DIV)) uut (
        .sys_clk           (sys_clk),
        .nrst              (nrst),
        .primary_ref_a     (clk_a),
        .primary_ref_b     (clk_b),
        .monitor_ref_in    (clk_m),
        .active_ref_sel    (active_ref_sel),
        .requested_ref_sel (requested_ref_sel),
        .addr              (addr),
        .wr_data           (wr_data),
        .wr_en             (wr_en),
        .rd_en             (rd_en),
        .rd_data           (rd_data),
        .ref_status_pin    (ref_status_pin),
        .irq               (irq)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        @(posedge sys_clk);
        d = rd_data;
    endtask : rd

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Polls the status register until the frequency code shows up, bounded.
    task automatic wait_code(input logic [1:0] c);
        for (int i = 0; i < 16000; i++) begin
            rd(fm_pkg::ADDR_STATUS, s);
            if (s[5:4] === c) break;
        end
    endtask : wait_code

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    initial begin
        repeat (100000) @(posedge sys_clk);
        n_fail++;
        complete_run();
    end

    initial begin
        n_fail = 0;
        check_count = 0;
        nrst = 1'b0;
        run = 3'b000;
        active_ref_sel = 1'b0;
        requested_ref_sel = 1'b0;
        addr = '0;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        // The pin launched at the first edge after release is seen at the second.
        repeat (2) @(posedge sys_clk);
        check("pin", {7'h00, ref_status_pin}, 8'h01);
        rd(fm_pkg::ADDR_CONFIG, s);
        check("config", s, fm_pkg::CONFIG_RESET);
        rd(fm_pkg::ADDR_IRQ_MASK, s);
        check("mask", s, fm_pkg::MASK_RESET);
        rd(fm_pkg::ADDR_STATUS, s);
        check("status", s, 8'h07);
        rd(12'h055, s);
        check("unmapped", s, 8'h00);
        wr(fm_pkg::ADDR_STATUS, 8'hff);
        rd(fm_pkg::ADDR_STATUS, s);
        check("status ro", s, 8'h07);
        for (int i = 0; i < 8; i++) begin
            wr(fm_pkg::ADDR_CONFIG, {2'b01, 1'b0, 3'(i), 2'(i)});
            rd(fm_pkg::ADDR_CONFIG, s);
            check("config rw", s, {2'b01, 1'b0, 3'(i), 2'(i)});
        end
        $display("test reset and registers done");

        run <= 3'b111;
        wr(fm_pkg::ADDR_IRQ_MASK, 8'h02);
        repeat (200) @(posedge sys_clk);
        rd(fm_pkg::ADDR_STATUS, s);
        check("status clocks", s, 8'h00);
        run <= 3'b101;
        repeat (200) @(posedge sys_clk);
        rd(fm_pkg::ADDR_STATUS, s);
        check("status b lost", s, 8'h02);
        check("pin req a", {7'h00, ref_status_pin}, 8'h00);
        check("irq", {7'h00, irq}, 8'h01);
        requested_ref_sel <= 1'b1;
        wr(fm_pkg::ADDR_IRQ_MASK, 8'h00);
        repeat (2) @(posedge sys_clk);
        check("pin req b", {7'h00, ref_status_pin}, 8'h01);
        check("irq masked", {7'h00, irq}, 8'h00);
        wr(fm_pkg::ADDR_IRQ_MASK, 8'h02);
        repeat (2) @(posedge sys_clk);
        check("irq unmasked", {7'h00, irq}, 8'h01);
        rd(fm_pkg::ADDR_IRQ_STATUS, s);
        check("irq status", s, 8'h02);
        rd(fm_pkg::ADDR_IRQ_STATUS, s);
        check("irq cleared", s, 8'h00);
        check("irq low", {7'h00, irq}, 8'h00);
        requested_ref_sel <= 1'b0;
        run <= 3'b111;
        $display("test loss of reference done");

        // monitored primary runs at 25 MHz
        wr(fm_pkg::ADDR_CONFIG, 8'h83);
        repeat (13000) @(posedge sys_clk);
        rd(fm_pkg::ADDR_STATUS, s);
        check("status valid", s, 8'h00);
        check("pin valid", {7'h00, ref_status_pin}, 8'h00);
        wr(fm_pkg::ADDR_CONFIG, 8'ha3);
        wait_code(2'h2);
        check("status fast", s, 8'h20);
        check("pin fast", {7'h00, ref_status_pin}, 8'h01);
        rd(fm_pkg::ADDR_IRQ_STATUS, s);
        check("irq freq", s, 8'h08);
        $display("test valid and fast done");

        wr(fm_pkg::ADDR_CONFIG, 8'h83);
        active_ref_sel <= 1'b1;
        wait_code(2'h1);
        check("status slow", s, 8'h18);
        check("pin slow", {7'h00, ref_status_pin}, 8'h01);
        run <= 3'b011;
        wait_code(2'h3);
        check("status indet", s, 8'h3c);
        check("pin indet", {7'h00, ref_status_pin}, 8'h01);
        wr(fm_pkg::ADDR_CONFIG, 8'h03);
        repeat (3) @(posedge sys_clk);
        rd(fm_pkg::ADDR_STATUS, s);
        check("status off", s, 8'h0c);
        check("pin off", {7'h00, ref_status_pin}, 8'h00);
        $display("test slow, fault and disable done");
        complete_run();
    end
endmodule : reference_frequency_monitor_test
